// >>> flash_cmd_consts.vh
// opcodes, framing counts and discovery header bytes for the flash command
// block; included by the command block and its header table.
`ifndef FLASH_CMD_CONSTS_VH
`define FLASH_CMD_CONSTS_VH

`define OP_RESUME 8'h30
`define OP_NOP 8'h00
`define OP_RESET_ARM 8'h66
`define OP_RESET 8'h99
`define OP_TABLE_READ 8'h5A

`define BITS_OPCODE 6'd8
`define BITS_ADDR_END 6'd32
`define BITS_DUMMY_END 6'd40
`define BITS_SPI_STEP 6'd1
`define BITS_QUAD_STEP 6'd4
`define SYNC_IDLE 6'h3F

`define TBL_SIG0 8'h53
`define TBL_SIG1 8'h46
`define TBL_SIG2 8'h44
`define TBL_SIG3 8'h50
`define TBL_MINOR 8'h00
`define TBL_MAJOR 8'h01
`define TBL_HDR_COUNT 8'h01
`define TBL_STD_ID 8'h00
`define TBL_STD_LEN 8'h09
`define TBL_STD_PTR 8'h30
`define TBL_VND_LEN 8'h04
`define TBL_VND_PTR 8'h60
`define TBL_UNUSED 8'hFF
`define TBL_ZERO 8'h00

`endif

// >>> sfdp_hdr_rom.v
// discovery header table: 24 bytes, registered read data.
// assumes the caller holds the address steady for a cycle before use.
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_consts.vh"
module sfdp_hdr_rom #(
    parameter [7:0] VENDOR_ID = 8'h5E // arbitrary value
) (
    input wire ref_clk_i,
    input wire [23:0] addr_i,
    output reg [7:0] data_o
);
    reg [7:0] data_d;

    always @* begin
        data_d = `TBL_UNUSED;
        if (addr_i[23:5] == 19'h00000) begin
            case (addr_i[4:0])
                5'h00: data_d = `TBL_SIG0;
                5'h01: data_d = `TBL_SIG1;
                5'h02: data_d = `TBL_SIG2;
                5'h03: data_d = `TBL_SIG3;
                5'h04: data_d = `TBL_MINOR;
                5'h05: data_d = `TBL_MAJOR;
                5'h06: data_d = `TBL_HDR_COUNT;
                5'h08: data_d = `TBL_STD_ID;
                5'h09: data_d = `TBL_MINOR;
                5'h0A: data_d = `TBL_MAJOR;
                5'h0B: data_d = `TBL_STD_LEN;
                5'h0C: data_d = `TBL_STD_PTR;
                5'h0D: data_d = `TBL_ZERO;
                5'h0E: data_d = `TBL_ZERO;
                5'h10: data_d = VENDOR_ID;
                5'h11: data_d = `TBL_MINOR;
                5'h12: data_d = `TBL_MAJOR;
                5'h13: data_d = `TBL_VND_LEN;
                5'h14: data_d = `TBL_VND_PTR;
                5'h15: data_d = `TBL_ZERO;
                5'h16: data_d = `TBL_ZERO;
                default: data_d = `TBL_UNUSED;
            endcase
        end
    end

    always @(posedge ref_clk_i) begin
        data_o <= data_d;
    end
endmodule
`default_nettype wire

// >>> flash_resume_reset_sfdp.v
// command handling for resume, no-op, two-step software reset and the
// single-line discovery header read. link pins are sampled by ref_clk_i, which must run
// well above the serial clock (at least 6x); mode 0 framing, data out on
// the falling serial edge.
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_consts.vh"
module flash_resume_reset_sfdp #(
    parameter [7:0] VENDOR_ID = 8'h5E // arbitrary value
) (
    input wire ref_clk_i,
    input wire rst_i,
    input wire cs_n_i,
    input wire sclk_i,
    input wire [3:0] sio_i,
    output reg [3:0] sio_o,
    output reg [3:0] sio_oe_o,
    input wire quad_command_mode_i,
    input wire perf_enhance_i,
    input wire write_start_i,
    input wire write_done_i,
    input wire erase_suspend_i,
    input wire program_suspend_i,
    output reg erase_suspended_flag_o,
    output reg program_suspended_flag_o,
    output reg busy_o,
    output reg resume_o,
    output reg reset_armed_o,
    output reg soft_reset_o,
    output reg write_abort_o
);
    // two-flop synchronisers; stage 1 is read only by stage 2
    reg [5:0] sync1_q;
    reg [5:0] sync2_q;
    reg cs_n_dly_q;
    reg sclk_dly_q;

    wire cs_n_s = sync2_q[5];
    wire sclk_s = sync2_q[4];
    wire [3:0] io_s = sync2_q[3:0];
    wire sclk_rise = sclk_s & ~sclk_dly_q;
    wire sclk_fall = ~sclk_s & sclk_dly_q;
    wire cs_fall = ~cs_n_s & cs_n_dly_q;
    wire cs_rise = cs_n_s & ~cs_n_dly_q;

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            sync1_q <= `SYNC_IDLE;
            sync2_q <= `SYNC_IDLE;
            cs_n_dly_q <= 1'b1;
            sclk_dly_q <= 1'b1;
        end else begin
            sync1_q <= {cs_n_i, sclk_i, sio_i};
            sync2_q <= sync1_q;
            cs_n_dly_q <= cs_n_s;
            sclk_dly_q <= sclk_s;
        end
    end

    // frame shifter
    reg [5:0] bit_cnt_q;
    reg [5:0] bit_cnt_d;
    reg [7:0] opcode_q;
    reg [7:0] opcode_d;
    reg [23:0] addr_q;
    reg [23:0] addr_d;
    reg quad_q;
    reg quad_d;
    reg out_phase_q;
    reg out_phase_d;
    reg [2:0] out_cnt_q;
    reg [2:0] out_cnt_d;
    reg [7:0] out_sh_q;
    reg [7:0] out_sh_d;
    wire [7:0] rom_data;

    sfdp_hdr_rom #(
        .VENDOR_ID(VENDOR_ID)
    ) u_rom (
        .ref_clk_i(ref_clk_i),
        .addr_i(addr_q),
        .data_o(rom_data)
    );

    always @* begin
        bit_cnt_d = bit_cnt_q;
        opcode_d = opcode_q;
        addr_d = addr_q;
        quad_d = quad_q;
        out_phase_d = out_phase_q;
        out_cnt_d = out_cnt_q;
        out_sh_d = out_sh_q;
        if (cs_fall) begin
            // mode latched per frame so a mid-frame change cannot split it
            bit_cnt_d = 6'd0;
            quad_d = quad_command_mode_i;
            out_phase_d = 1'b0;
            out_cnt_d = 3'd0;
        end else if (cs_n_s) begin
            out_phase_d = 1'b0;
        end else if (sclk_rise && !out_phase_q) begin
            if (bit_cnt_q < `BITS_OPCODE) begin
                if (quad_q) begin
                    opcode_d = {opcode_q[3:0], io_s};
                    bit_cnt_d = bit_cnt_q + `BITS_QUAD_STEP;
                end else begin
                    // upper lines ignored in single-line mode
                    opcode_d = {opcode_q[6:0], io_s[0]};
                    bit_cnt_d = bit_cnt_q + `BITS_SPI_STEP;
                end
            end else if (opcode_q == `OP_TABLE_READ && !quad_q) begin
                if (bit_cnt_q < `BITS_ADDR_END) begin
                    addr_d = {addr_q[22:0], io_s[0]};
                end
                bit_cnt_d = bit_cnt_q + `BITS_SPI_STEP;
                if (bit_cnt_q + `BITS_SPI_STEP == `BITS_DUMMY_END) begin
                    out_phase_d = 1'b1;
                end
            end else if (bit_cnt_q != 6'h3F) begin
                bit_cnt_d = bit_cnt_q + `BITS_SPI_STEP;
            end
        end else if (sclk_fall && out_phase_q) begin
            out_cnt_d = out_cnt_q + 3'd1;
            if (out_cnt_q == 3'd0) begin
                out_sh_d = rom_data;
                addr_d = addr_q + 24'd1;
            end else begin
                out_sh_d = {out_sh_q[6:0], 1'b0};
            end
        end
    end

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            bit_cnt_q <= 6'd0;
            opcode_q <= 8'h00;
            addr_q <= 24'h000000;
            quad_q <= 1'b0;
            out_phase_q <= 1'b0;
            out_cnt_q <= 3'd0;
            out_sh_q <= 8'h00;
        end else if (soft_reset_o) begin
            // frame state is volatile as well; a new cs fall
            // cannot arrive in this cycle while cs stays high two clocks
            bit_cnt_q <= 6'd0;
            opcode_q <= 8'h00;
            addr_q <= 24'h000000;
            quad_q <= 1'b0;
            out_phase_q <= 1'b0;
            out_cnt_q <= 3'd0;
            out_sh_q <= 8'h00;
        end else begin
            bit_cnt_q <= bit_cnt_d;
            opcode_q <= opcode_d;
            addr_q <= addr_d;
            quad_q <= quad_d;
            out_phase_q <= out_phase_d;
            out_cnt_q <= out_cnt_d;
            out_sh_q <= out_sh_d;
        end
    end

    // serial output follows the shifter; first bit appears with the load
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            sio_o <= 4'h0;
            sio_oe_o <= 4'h0;
        end else begin
            sio_o <= {2'b00, out_sh_d[7], 1'b0};
            sio_oe_o <= {2'b00, out_phase_d & ~cs_n_s, 1'b0};
        end
    end

    // frame end: one-byte commands act only on an exact byte boundary
    wire frame_byte = cs_rise && (bit_cnt_q == `BITS_OPCODE);
    wire frame_any = cs_rise && (bit_cnt_q >= `BITS_OPCODE);
    wire cmd_resume = frame_byte && opcode_q == `OP_RESUME;
    wire cmd_arm = frame_byte && opcode_q == `OP_RESET_ARM;
    wire cmd_reset = frame_byte && opcode_q == `OP_RESET && reset_armed_o;

    // write state
    reg active_q;
    reg active_d;
    reg armed_d;
    reg esf_d;
    reg psf_d;
    reg resume_d;
    reg soft_reset_d;
    reg abort_d;

    always @* begin
        active_d = active_q;
        armed_d = reset_armed_o;
        esf_d = erase_suspended_flag_o;
        psf_d = program_suspended_flag_o;
        resume_d = 1'b0;
        soft_reset_d = 1'b0;
        abort_d = 1'b0;
        if (write_done_i) begin
            active_d = 1'b0;
        end
        if (write_start_i) begin
            active_d = 1'b1;
        end
        if (frame_any) begin
            // any completed command other than reset-arm disarms; a nop
            // does only that
            armed_d = cmd_arm;
        end
        if (cmd_resume && !perf_enhance_i &&
                (erase_suspended_flag_o || program_suspended_flag_o)) begin
            esf_d = 1'b0;
            psf_d = 1'b0;
            resume_d = 1'b1;
        end
        if (cmd_reset) begin
            soft_reset_d = 1'b1;
            abort_d = active_q;
            active_d = 1'b0;
            esf_d = 1'b0;
            psf_d = 1'b0;
            armed_d = 1'b0;
        end
        // a suspend landing with a resume keeps its flag; one landing with a reset is dropped
        if (erase_suspend_i && active_d && !cmd_reset) begin
            esf_d = 1'b1;
        end
        if (program_suspend_i && active_d && !cmd_reset) begin
            psf_d = 1'b1;
        end
    end

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            active_q <= 1'b0;
            reset_armed_o <= 1'b0;
            erase_suspended_flag_o <= 1'b0;
            program_suspended_flag_o <= 1'b0;
            busy_o <= 1'b0;
            resume_o <= 1'b0;
            soft_reset_o <= 1'b0;
            write_abort_o <= 1'b0;
        end else begin
            active_q <= active_d;
            reset_armed_o <= armed_d;
            erase_suspended_flag_o <= esf_d;
            program_suspended_flag_o <= psf_d;
            busy_o <= active_d & ~esf_d & ~psf_d;
            resume_o <= resume_d;
            soft_reset_o <= soft_reset_d;
            write_abort_o <= abort_d;
        end
    end
endmodule
`default_nettype wire

// >>> flash_cmd_checker.sv
// checker for the flash command block, bound to its top module ports.
// assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_checker (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic cs_n_i,
    input wire logic perf_enhance_i,
    input wire logic [3:0] sio_oe_o,
    input wire logic erase_suspended_flag_o,
    input wire logic program_suspended_flag_o,
    input wire logic busy_o,
    input wire logic resume_o,
    input wire logic reset_armed_o,
    input wire logic soft_reset_o,
    input wire logic write_abort_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    sequence cs_quiet;
        cs_n_i [*6];
    endsequence
    sequence cs_active;
        !cs_n_i [*6];
    endsequence
    a_abort_with_reset: assert property (
        write_abort_o |-> soft_reset_o) else $error("abort alone");
    a_reset_needs_arm: assert property (
        soft_reset_o |-> $past(reset_armed_o)) else $error("reset unarmed");
    a_reset_clears_state: assert property (
        soft_reset_o |=> !(busy_o || reset_armed_o || erase_suspended_flag_o
        || program_suspended_flag_o)) else $error("state kept");
    a_resume_one_cycle: assert property (
        resume_o |=> !resume_o) else $error("resume too long");
    a_resume_clears_flags: assert property (
        resume_o |-> !erase_suspended_flag_o && !program_suspended_flag_o)
        else $error("flag kept");
    a_resume_sets_busy: assert property (
        resume_o |-> busy_o) else $error("not busy");
    a_resume_when_allowed: assert property (
        resume_o |-> !$past(perf_enhance_i) && $past(erase_suspended_flag_o
        || program_suspended_flag_o)) else $error("resume not allowed");
    a_oe_serial_only: assert property (
        sio_oe_o[3:2] == 2'b00 && !sio_oe_o[0]) else $error("wrong oe");
    a_oe_released: assert property (
        cs_quiet |-> !sio_oe_o[1]) else $error("oe while deselected");
    a_armed_steady: assert property (
        cs_active |-> $stable(reset_armed_o)) else $error("arm mid frame");
endmodule
bind flash_resume_reset_sfdp flash_cmd_checker chk_i (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i),
    .perf_enhance_i(perf_enhance_i), .sio_oe_o(sio_oe_o),
    .erase_suspended_flag_o(erase_suspended_flag_o),
    .program_suspended_flag_o(program_suspended_flag_o),
    .busy_o(busy_o), .resume_o(resume_o), .reset_armed_o(reset_armed_o),
    .soft_reset_o(soft_reset_o), .write_abort_o(write_abort_o));
`default_nettype wire

// >>> host_model.sv
// host controller model: frames commands on the link pins, mode 0.
// assumes the bench feeds back the resolved io wire; half is in ref clocks.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic ref_clk_i,
    input wire logic [3:0] io_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic [3:0] io_o
);
    int half = 4;
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        io_o = 4'h0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    task automatic pulse(input logic [3:0] d, output logic b);
        sclk_o = 1'b0;
        io_o = d;
        tick(half);
        b = io_i[1];
        sclk_o = 1'b1;
        tick(half);
    endtask
    // upper lines carry junk in single-line mode on purpose
    task automatic put(input logic [7:0] v, input logic q);
        logic b;
        if (q) begin
            pulse(v[7:4], b);
            pulse(v[3:0], b);
        end else begin
            for (int i = 7; i >= 0; i--) begin
                pulse({3'($urandom), v[i]}, b);
            end
        end
    endtask
    // released input lines toggle every serial clock so stale data cannot pass
    task automatic get(output logic [7:0] v);
        for (int i = 7; i >= 0; i--) pulse(~io_o, v[i]);
    endtask
    task automatic open_f;
        cs_n_o = 1'b0;
        tick(3);
    endtask
    task automatic close_f;
        sclk_o = 1'b0;
        io_o = ~io_o;
        tick(half);
        cs_n_o = 1'b1;
        tick(8);
    endtask
endmodule
`default_nettype wire

// >>> flash_resume_reset_sfdp_test.sv
// self-checking bench for the flash command block with a host model.
// assumes the command constants header is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_consts.vh"
module flash_resume_reset_sfdp_test;
    localparam logic [7:0] VID = 8'hA7; // arbitrary value
    logic ref_clk_i, rst_i, quad, perf, wstart, wdone, esus, psus;
    wire cs_n, sclk, e_f, p_f, busy, res, armed, srst, abt;
    wire [3:0] hio, dio, doe, sio;
    int n_errors = 0, total_checks = 0, n_res = 0, n_rst = 0, n_abt = 0;
    int r0;
    logic b0;
    logic [7:0] v0;
    assign sio = (doe & dio) | (~doe & hio);
    flash_resume_reset_sfdp #(.VENDOR_ID(VID)) flash_resume_reset_sfdp_i (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sclk_i(sclk),
        .sio_i(sio), .sio_o(dio), .sio_oe_o(doe), .quad_command_mode_i(quad),
        .perf_enhance_i(perf), .write_start_i(wstart), .write_done_i(wdone),
        .erase_suspend_i(esus), .program_suspend_i(psus),
        .erase_suspended_flag_o(e_f), .program_suspended_flag_o(p_f),
        .busy_o(busy), .resume_o(res), .reset_armed_o(armed),
        .soft_reset_o(srst), .write_abort_o(abt));
    host_model host_model_i (.ref_clk_i(ref_clk_i), .io_i(sio),
        .cs_n_o(cs_n), .sclk_o(sclk), .io_o(hio));
    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        if (res === 1'b1) n_res <= n_res + 1;
        if (srst === 1'b1) n_rst <= n_rst + 1;
        if (abt === 1'b1) n_abt <= n_abt + 1;
    end
    function automatic logic [7:0] tbl(input int a);
        case (a)
            0: return 8'h53;
            1: return 8'h46;
            2: return 8'h44;
            3: return 8'h50;
            5, 6, 10, 18: return 8'h01;
            4, 8, 9, 13, 14, 17, 21, 22: return 8'h00;
            11: return 8'h09;
            12: return 8'h30;
            16: return VID;
            19: return 8'h04;
            20: return 8'h60;
            default: return 8'hFF;
        endcase
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic hit(ref logic s);
        s = 1'b1;
        @(negedge ref_clk_i);
        s = 1'b0;
        @(negedge ref_clk_i);
    endtask
    task automatic cmd(input logic [7:0] op, input logic q);
        quad = q;
        host_model_i.open_f;
        host_model_i.put(op, q);
        host_model_i.close_f;
    endtask
    task automatic rd(input int a, input int n);
        logic [7:0] v;
        quad = 1'b0;
        host_model_i.open_f;
        host_model_i.put(`OP_TABLE_READ, 1'b0);
        for (int i = 2; i >= 0; i--) begin
            host_model_i.put(a[8*i+:8], 1'b0);
        end
        host_model_i.put(8'($urandom), 1'b0);
        for (int i = 0; i < n; i++) begin
            host_model_i.get(v);
            check(v, tbl(a + i));
        end
        host_model_i.close_f;
    endtask
    initial begin
        {rst_i, quad, perf, wstart, wdone, esus, psus} = 7'h40;
        void'($urandom(32'h4AFBC5D4));
        repeat (2) @(negedge ref_clk_i);
        rst_i = 1'b0;
        host_model_i.tick(4);
        rd(0, 24);
        repeat (6) rd($urandom_range(23, 0), $urandom_range(5, 1));
        host_model_i.half = 6;
        rd(24'h15, 4);
        host_model_i.half = 4;
        for (int k = 0; k < 2; k++) begin
            r0 = n_res;
            hit(wstart);
            if (k == 1) hit(psus);
            else hit(esus);
            check({busy, e_f, p_f}, k == 1 ? 3'b001 : 3'b010);
            perf = 1'b1;
            cmd(`OP_RESUME, k[0]);
            check(n_res - r0, 0);
            perf = 1'b0;
            cmd(`OP_RESUME, k[0]);
            check({busy, e_f, p_f}, 3'b100);
            cmd(`OP_RESUME, 1'b0);
            check(n_res - r0, 1);
            host_model_i.tick(20000);
        end
        r0 = n_rst;
        cmd(`OP_RESET, 1'b0);
        check(n_rst - r0, 0);
        cmd(`OP_RESET_ARM, 1'b1);
        check(armed, 1'b1);
        cmd(`OP_NOP, 1'b1);
        check({armed, busy}, 2'b01);
        cmd(`OP_RESET_ARM, 1'b0);
        rd(5, 1);
        cmd(`OP_RESET, 1'b0);
        check(n_rst - r0, 0);
        cmd(`OP_RESET_ARM, 1'b0);
        cmd(`OP_RESET, 1'b1);
        check(n_rst - r0, 1);
        check(n_abt, 1);
        check({busy, armed, e_f, p_f}, 4'h0);
        host_model_i.tick(20);
        hit(wstart);
        check(busy, 1'b1);
        hit(wdone);
        check(busy, 1'b0);
        // a byte command one bit too long is refused but still disarms
        cmd(`OP_RESET_ARM, 1'b0);
        check(armed, 1'b1);
        quad = 1'b0;
        host_model_i.open_f;
        host_model_i.put(`OP_RESET, 1'b0);
        host_model_i.pulse(4'h0, b0);
        host_model_i.close_f;
        check(armed, 1'b0);
        check(n_rst - r0, 1);
        // table read cut in mid-byte; the next read must still work
        host_model_i.open_f;
        host_model_i.put(`OP_TABLE_READ, 1'b0);
        repeat (4) host_model_i.put(8'h00, 1'b0);
        host_model_i.get(v0);
        check(v0, tbl(0));
        repeat (3) host_model_i.pulse(4'h0, b0);
        host_model_i.close_f;
        check(doe, 4'h0);
        rd(0, 4);
        close_out;
    end
    initial begin
        repeat (90000) @(posedge ref_clk_i);
        n_errors++;
        close_out;
    end
endmodule
`default_nettype wire
